//--- core/nic_lbi_pkg.sv
// Shared constants and types for the local bus interface block.
// Assumes one 20 MHz bus clock drives every flip-flop of the block.
package nic_lbi_pkg;

	// Bus clock rate and memory cycle shape
	localparam int unsigned CLK_HZ       = 20_000_000; // Bus clock rate
	localparam int unsigned DMA_STATES   = 4;          // t1..t4 per cycle
	localparam int unsigned SYNC_STAGES  = 2;          // Pin synchroniser
	// Synchroniser reset: pins at rest, so no false edge or grant follows
	localparam logic [27:0] PIN_IDLE     = 28'hf0f_ffff;

	// Register select codes of the slave port
	localparam logic [3:0] REG_CTRL      = 4'h0;  // Mode bits
	localparam logic [3:0] REG_RADDR_LO  = 4'h1;  // Remote address low
	localparam logic [3:0] REG_RADDR_HI  = 4'h2;  // Remote address high
	localparam logic [3:0] REG_RCNT_LO   = 4'h3;  // Remote count low
	localparam logic [3:0] REG_RCNT_HI   = 4'h4;  // Remote count high
	localparam logic [3:0] REG_STATUS    = 4'h5;  // Read-only state

	// Control register fields and reset value
	localparam int unsigned CTRL_WORD_BIT = 0;     // 1: word transfers
	localparam int unsigned CTRL_RDIR_BIT = 1;     // 1: remote read
	localparam logic [7:0]  CTRL_RESET    = 8'h00; // Byte mode, write

	// Bus cycle states
	typedef enum logic [2:0] {
		ST_IDLE, ST_T1, ST_T2, ST_T3, ST_TW, ST_T4
	} bus_state_t;

	// Kind of memory cycle in flight
	typedef enum logic [1:0] {
		CY_LOCAL_WR, CY_REMOTE_WR, CY_REMOTE_RD
	} cycle_kind_t;

endpackage : nic_lbi_pkg

//--- core/nic_stream_if.sv
// Valid/ready word stream between the block's own modules.
// Assumes both ends share the bus clock.
`timescale 1ns/1ps
interface nic_stream_if #(parameter int unsigned W = 32);
	logic         valid; // Word offered
	logic         ready; // Word can be taken
	logic [W-1:0] data;  // Word contents
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : nic_stream_if

//--- core/nic_word_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module nic_word_fifo #(
	parameter int unsigned W     = 32, // Word width
	parameter int unsigned DEPTH = 8   // Number of words
) (
	// Clock and reset
	input  wire logic  clk,
	input  wire logic  srst,
	// Fill and drain sides
	nic_stream_if.snk  in_s,
	nic_stream_if.src  out_s
);
	localparam int unsigned AW = $clog2(DEPTH);
	localparam int unsigned CW = $clog2(DEPTH + 1);

	// Power of two keeps pointer wrap free
	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
		$error("DEPTH must be a power of two of at least 2");
	end

	logic [W-1:0]  mem_r [DEPTH]; // Word storage
	logic [AW-1:0] wr_ptr_r;      // Next slot to fill
	logic [AW-1:0] rd_ptr_r;      // Oldest word
	logic [CW-1:0] count_r;       // Words held
	logic [CW-1:0] count_nxt;     // Count after this edge
	logic          push;          // Word accepted
	logic          pop;           // Word taken

	assign push = in_s.valid && in_s.ready;
	assign pop  = out_s.valid && out_s.ready;

	////////////////////////////////////////////////////////////////////
	// Occupancy
	always_comb begin
		count_nxt = count_r;
		if (push && !pop) begin
			count_nxt = count_r + CW'(1);
		end else if (pop && !push) begin
			count_nxt = count_r - CW'(1);
		end
	end

	// Count and registered flags, so ready is a flop
	always_ff @(posedge clk) begin
		if (srst) begin
			count_r     <= '0;
			in_s.ready  <= 1'b1;
			out_s.valid <= 1'b0;
		end else begin
			count_r     <= count_nxt;
			in_s.ready  <= (count_nxt != CW'(DEPTH));
			out_s.valid <= (count_nxt != '0);
		end
	end

	// Pointers and storage
	always_ff @(posedge clk) begin
		if (srst) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
		end else begin
			if (push) begin
				mem_r[wr_ptr_r] <= in_s.data;
				wr_ptr_r        <= wr_ptr_r + AW'(1);
			end
			if (pop) begin
				rd_ptr_r <= rd_ptr_r + AW'(1);
			end
		end
	end

	// Head word, valid only while out_s.valid is high
	assign out_s.data = mem_r[rd_ptr_r];

endmodule : nic_word_fifo

//--- core/nic_local_bus_interface.sv
// Local bus interface: slave register port, DMA memory cycles on the
// multiplexed bus and the external latch handshakes of remote DMA.
// Assumes clk is the bus clock; every pin input is asynchronous.
`timescale 1ns/1ps

module nic_local_bus_interface
	import nic_lbi_pkg::*;
#(
	parameter int unsigned FIFO_DEPTH = 8 // Local write buffer depth
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        srst,
	// Host slave port pins
	input  wire logic        slave_sel_n,
	input  wire logic [3:0]  register_select,
	input  wire logic        slave_write_strobe_n,
	input  wire logic        slave_read_strobe_n,
	output logic             access_ack_n,
	// Multiplexed bus and address strobe
	input  wire logic [15:0] bus_in,
	output logic [15:0]      bus_out,
	output logic             bus_oe_lo,
	output logic             bus_oe_hi,
	input  wire logic        addr_latch_strobe_in,
	output logic             addr_latch_strobe_out,
	output logic             addr_latch_strobe_oe,
	// Master strobes
	output logic             master_write_strobe_n,
	output logic             master_read_strobe_n,
	output logic             master_strobe_oe,
	input  wire logic        ready,
	// Arbitration
	output logic             bus_request_out,
	input  wire logic        bus_grant,
	// External latch handshakes
	output logic             port_read_enable_n,
	output logic             port_write_strobe_n,
	output logic             remote_port_request,
	input  wire logic        latch_read_done,
	input  wire logic        latch_write_done,
	// Local write words {addr, data} from the block's own logic
	input  wire logic        push_valid,
	output logic             push_ready,
	input  wire logic [31:0] push_data
);
	////////////////////////////////////////////////////////////////////
	// Pin synchronisers: first stage read only by the second
	localparam int unsigned NPIN = 28;
	logic [NPIN-1:0] pin_s1_r;  // First stage
	logic [NPIN-1:0] pin_s2_r;  // Safe copy
	logic            cs_n_s, swr_n_s, srd_n_s, als_s, rdy_s, grant_s;
	logic            latch_read_done_s, latch_write_done_s;
	logic [3:0]      ra_s;
	logic [15:0]     bus_s;

	always_ff @(posedge clk) begin
		if (srst) begin
			pin_s1_r <= PIN_IDLE;
			pin_s2_r <= PIN_IDLE;
		end else begin
			pin_s1_r <= {slave_sel_n, slave_write_strobe_n,
			             slave_read_strobe_n, addr_latch_strobe_in, ready,
			             bus_grant, latch_read_done, latch_write_done,
			             register_select, bus_in};
			pin_s2_r <= pin_s1_r;
		end
	end
	assign {cs_n_s, swr_n_s, srd_n_s, als_s, rdy_s, grant_s, latch_read_done_s,
	        latch_write_done_s, ra_s, bus_s} = pin_s2_r;

	////////////////////////////////////////////////////////////////////
	// Local write buffer
	nic_stream_if #(.W(32)) fill_s ();
	nic_stream_if #(.W(32)) drain_s ();
	assign fill_s.valid = push_valid;
	assign fill_s.data  = push_data;
	assign push_ready   = fill_s.ready;

	nic_word_fifo #(.W(32), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk   (clk),
		.srst  (srst),
		.in_s  (fill_s),
		.out_s (drain_s)
	);

	////////////////////////////////////////////////////////////////////
	// State and edge history
	bus_state_t  state_r, state_nxt;  // Memory cycle state
	cycle_kind_t kind_r, kind_nxt;    // Cycle in flight
	logic [15:0] addr_r;              // Cycle address
	logic [15:0] wdata_r;             // Local write data
	logic        latch_read_done_d_r, latch_write_done_d_r;  // Previous handshake levels
	logic        swr_d_r, als_d_r;    // Previous strobe levels
	logic        rw_pend_r, rr_pend_r;// Remote cycles waiting
	logic        rem_run_r;           // Remote cycle started
	logic [7:0]  ctrl_r;              // Mode bits
	logic [15:0] rem_addr_r;          // Remote address pointer
	logic [15:0] rem_cnt_r;           // Remote transfers left
	logic [3:0]  sel_r;               // Register select latch
	logic [7:0]  rd_data_r;           // Slave read data
	logic        slv_seen_r;          // Access seen last cycle
	logic        work;                // Something to do
	logic        start;               // Cycle begins
	logic        dma_active;          // Bus in master use
	logic        slv_act;             // Host access in progress
	logic        word_mode;           // Word transfers
	logic        data_phase;          // t2, t3, tw or t4 next

	assign word_mode  = ctrl_r[CTRL_WORD_BIT];
	assign work       = drain_s.valid || rw_pend_r || rr_pend_r;
	assign start      = (state_r == ST_IDLE) && grant_s && work;
	assign dma_active = (state_r != ST_IDLE) || grant_s;
	assign slv_act    = !cs_n_s && (!srd_n_s || !swr_n_s);

	////////////////////////////////////////////////////////////////////
	// Cycle sequencer: t1..t4 with waits after t3 only
	always_comb begin
		state_nxt = state_r;
		kind_nxt  = kind_r;
		unique case (state_r)
			ST_IDLE: begin
				if (start) begin
					state_nxt = ST_T1;
					// Remote handshakes win over buffered writes
					if (rw_pend_r) begin
						kind_nxt = CY_REMOTE_WR;
					end else if (rr_pend_r) begin
						kind_nxt = CY_REMOTE_RD;
					end else begin
						kind_nxt = CY_LOCAL_WR;
					end
				end
			end
			ST_T1:   state_nxt = ST_T2;
			ST_T2:   state_nxt = ST_T3;
			ST_T3:   state_nxt = rdy_s ? ST_TW : ST_T4;
			ST_TW:   state_nxt = rdy_s ? ST_TW : ST_T4;
			ST_T4:   state_nxt = ST_IDLE;
		endcase
	end
	assign drain_s.ready = start && !rw_pend_r && !rr_pend_r;
	assign data_phase = (state_nxt != ST_IDLE) && (state_nxt != ST_T1);

	always_ff @(posedge clk) begin
		if (srst) begin
			state_r <= ST_IDLE;
			kind_r  <= CY_LOCAL_WR;
			addr_r  <= '0;
			wdata_r <= '0;
		end else begin
			state_r <= state_nxt;
			kind_r  <= kind_nxt;
			if (start) begin
				addr_r  <= drain_s.ready ? drain_s.data[31:16] : rem_addr_r;
				wdata_r <= drain_s.data[15:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Latch handshakes: set wins over clear
	always_ff @(posedge clk) begin
		if (srst) begin
			latch_read_done_d_r  <= 1'b0;
			latch_write_done_d_r  <= 1'b0;
			rw_pend_r <= 1'b0;
			rr_pend_r <= 1'b0;
			rem_run_r <= 1'b0;
		end else begin
			latch_read_done_d_r <= latch_read_done_s;
			latch_write_done_d_r <= latch_write_done_s;
			if (latch_write_done_s && !latch_write_done_d_r) begin
				rw_pend_r <= 1'b1;
			end else if (start && kind_nxt == CY_REMOTE_WR) begin
				rw_pend_r <= 1'b0;
			end
			if (latch_read_done_s && !latch_read_done_d_r) begin
				rr_pend_r <= 1'b1;
			end else if (start && kind_nxt == CY_REMOTE_RD) begin
				rr_pend_r <= 1'b0;
			end
			// Hold off a new port request until this transfer ends
			if ((latch_write_done_s && !latch_write_done_d_r) || (latch_read_done_s && !latch_read_done_d_r)) begin
				rem_run_r <= 1'b1;
			end else if (state_r == ST_T4 && kind_r != CY_LOCAL_WR) begin
				rem_run_r <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Slave port: select latch, acknowledge, registers
	always_ff @(posedge clk) begin
		if (srst) begin
			sel_r   <= '0;
			als_d_r <= 1'b0;
		end else begin
			als_d_r <= als_s;
			// Strobe high flows through; the value freezes one cycle after its fall
			if (!cs_n_s && !dma_active && als_s) begin
				sel_r <= ra_s;
			end else if (!cs_n_s && !dma_active && als_d_r) begin
				sel_r <= ra_s;
			end
		end
	end

	// Acknowledge goes low two cycles after the access is synchronised
	always_ff @(posedge clk) begin
		if (srst) begin
			slv_seen_r   <= 1'b0;
			access_ack_n <= 1'b1;
		end else begin
			slv_seen_r   <= slv_act;
			access_ack_n <= !(slv_act && slv_seen_r);
		end
	end

	// Writes on the rising slave write strobe; counters step per remote cycle
	always_ff @(posedge clk) begin
		if (srst) begin
			swr_d_r    <= 1'b1;
			ctrl_r     <= CTRL_RESET;
			rem_addr_r <= '0;
			rem_cnt_r  <= '0;
		end else begin
			swr_d_r <= swr_n_s;
			if (!cs_n_s && swr_n_s && !swr_d_r) begin
				unique case (sel_r)
					REG_CTRL:     ctrl_r           <= bus_s[7:0];
					REG_RADDR_LO: rem_addr_r[7:0]  <= bus_s[7:0];
					REG_RADDR_HI: rem_addr_r[15:8] <= bus_s[7:0];
					REG_RCNT_LO:  rem_cnt_r[7:0]   <= bus_s[7:0];
					REG_RCNT_HI:  rem_cnt_r[15:8]  <= bus_s[7:0];
					default:      ;
				endcase
			end else if (state_r == ST_T4 && kind_r != CY_LOCAL_WR) begin
				rem_addr_r <= rem_addr_r + (word_mode ? 16'h0002 : 16'h0001);
				rem_cnt_r  <= rem_cnt_r - 16'h0001;
			end
		end
	end

	// Read data mux
	always_ff @(posedge clk) begin
		if (srst) begin
			rd_data_r <= '0;
		end else begin
			unique case (sel_r)
				REG_CTRL:     rd_data_r <= ctrl_r;
				REG_RADDR_LO: rd_data_r <= rem_addr_r[7:0];
				REG_RADDR_HI: rd_data_r <= rem_addr_r[15:8];
				REG_RCNT_LO:  rd_data_r <= rem_cnt_r[7:0];
				REG_RCNT_HI:  rd_data_r <= rem_cnt_r[15:8];
				REG_STATUS:   rd_data_r <= {3'b000, rem_run_r, rw_pend_r,
				                            rr_pend_r, drain_s.valid,
				                            state_r == ST_IDLE};
				default:      rd_data_r <= 8'h00;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// Pin drivers, registered from the next state
	always_ff @(posedge clk) begin
		if (srst) begin
			bus_out   <= '0;
			bus_oe_lo <= 1'b0;
			bus_oe_hi <= 1'b0;
		end else if (state_nxt == ST_T1) begin
			bus_out   <= start ? (drain_s.ready ? drain_s.data[31:16]
			                                    : rem_addr_r) : addr_r;
			bus_oe_lo <= 1'b1;
			bus_oe_hi <= 1'b1;
		end else if (data_phase) begin
			// Byte mode keeps the high address byte on the upper lines
			bus_out   <= word_mode ? wdata_r : {addr_r[15:8], wdata_r[7:0]};
			bus_oe_lo <= (kind_r == CY_LOCAL_WR);
			bus_oe_hi <= !word_mode || (kind_r == CY_LOCAL_WR);
		end else begin
			bus_out   <= {8'h00, rd_data_r};
			bus_oe_lo <= !cs_n_s && !srd_n_s && !grant_s;
			bus_oe_hi <= 1'b0;
		end
	end

	// Strobes: low through t2, t3 and waits, rise entering t4; port read enable low through t4
	always_ff @(posedge clk) begin
		if (srst) begin
			master_write_strobe_n <= 1'b1;
			master_read_strobe_n  <= 1'b1;
			master_strobe_oe      <= 1'b0;
			addr_latch_strobe_out <= 1'b0;
			addr_latch_strobe_oe  <= 1'b0;
			port_read_enable_n    <= 1'b1;
			port_write_strobe_n   <= 1'b1;
		end else begin
			master_strobe_oe      <= grant_s || state_nxt != ST_IDLE;
			addr_latch_strobe_oe  <= grant_s || state_nxt != ST_IDLE;
			addr_latch_strobe_out <= (state_nxt == ST_T1);
			master_write_strobe_n <= !(data_phase && state_nxt != ST_T4 &&
			                           kind_nxt != CY_REMOTE_RD);
			master_read_strobe_n  <= !(data_phase && state_nxt != ST_T4 &&
			                           kind_nxt == CY_REMOTE_RD);
			port_write_strobe_n   <= !(data_phase && state_nxt != ST_T4 &&
			                           kind_nxt == CY_REMOTE_RD);
			port_read_enable_n    <= !(data_phase &&
			                           kind_nxt == CY_REMOTE_WR);
		end
	end

	// Arbitration and remote request
	always_ff @(posedge clk) begin
		if (srst) begin
			bus_request_out     <= 1'b0;
			remote_port_request <= 1'b0;
		end else begin
			bus_request_out     <= work || state_nxt != ST_IDLE;
			remote_port_request <= (rem_cnt_r != 16'h0000) &&
			                       !rem_run_r && !rw_pend_r && !rr_pend_r &&
			                       !(latch_write_done_s && !latch_write_done_d_r) &&
			                       !(latch_read_done_s && !latch_read_done_d_r);
		end
	end

	////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	property p_t1_addr;
		state_r == ST_T1 |-> bus_oe_lo && bus_oe_hi && bus_out == addr_r;
	endproperty
	a_t1_addr: assert property (p_t1_addr) else $error("t1 address");

	property p_four_states;
		state_r == ST_T1 |=> state_r == ST_T2 ##1 state_r == ST_T3;
	endproperty
	a_four_states: assert property (p_four_states)
		else $error("cycle shape broken");

	property p_ready_wait;
		state_r == ST_T3 && rdy_s |=> state_r == ST_TW;
	endproperty
	a_ready_wait: assert property (p_ready_wait)
		else $error("ready ignored in t3");

	property p_wait_strobes;
		state_r == ST_TW && kind_r == CY_LOCAL_WR |->
			!master_write_strobe_n && master_read_strobe_n;
	endproperty
	a_wait_strobes: assert property (p_wait_strobes)
		else $error("strobe wrong in wait");

	property p_wr_rise;
		state_r == ST_T4 && kind_r == CY_LOCAL_WR |->
			master_write_strobe_n && $past(!master_write_strobe_n);
	endproperty
	a_wr_rise: assert property (p_wr_rise)
		else $error("write strobe edge");

	property p_rd_strobe;
		state_r == ST_T3 && kind_r == CY_REMOTE_RD |->
			!master_read_strobe_n && !port_write_strobe_n;
	endproperty
	a_rd_strobe: assert property (p_rd_strobe)
		else $error("read strobe missing");

	property p_prd;
		state_r == ST_T2 && kind_r == CY_REMOTE_WR |->
			!port_read_enable_n && !bus_oe_lo;
	endproperty
	a_prd: assert property (p_prd) else $error("port read enable");

	property p_float;
		!grant_s && state_r == ST_IDLE |=> !master_strobe_oe;
	endproperty
	a_float: assert property (p_float) else $error("strobes driven");

	property p_ack;
		!slv_act |=> access_ack_n;
	endproperty
	a_ack: assert property (p_ack) else $error("early acknowledge");

	property p_byte_hi;
		data_phase && state_r == ST_T3 && !word_mode |->
			bus_oe_hi && bus_out[15:8] == addr_r[15:8];
	endproperty
	a_byte_hi: assert property (p_byte_hi)
		else $error("byte mode high lines");

	property p_bus_request_out;
		drain_s.valid |=> bus_request_out;
	endproperty
	a_bus_request_out: assert property (p_bus_request_out) else $error("no bus request");

	c_local_wr: cover property (state_r == ST_T4 && kind_r == CY_LOCAL_WR);
	c_remote_rd: cover property (state_r == ST_TW && kind_r == CY_REMOTE_RD);
	c_slave_wr: cover property (!cs_n_s && swr_n_s && !swr_d_r);

endmodule : nic_local_bus_interface

//--- test/lbi_far_side.sv
// Far side model: buffer memory, external data latch and bus wires.
// Assumes the device and this model share the bus clock.
`timescale 1ns/1ps
module lbi_far_side #(
	parameter logic [15:0] RDATA = 16'hc3a5 // Word returned on reads
) (
	// Clock
	input  wire logic        clk,
	// Device pins
	input  wire logic [15:0] bus_out,
	input  wire logic        bus_oe_lo,
	input  wire logic        bus_oe_hi,
	input  wire logic        addr_latch_strobe_out,
	input  wire logic        addr_latch_strobe_oe,
	input  wire logic        master_write_strobe_n,
	input  wire logic        master_read_strobe_n,
	input  wire logic        port_read_enable_n,
	input  wire logic        port_write_strobe_n,
	// Host drive and pacing
	input  wire logic        host_als,
	input  wire logic        host_oe,
	input  wire logic [15:0] host_data,
	input  wire logic        slow,
	input  wire logic [15:0] latch_fill,
	// Resolved wires
	output logic [15:0]      bus_in,
	output logic             addr_latch_strobe_in,
	output logic             ready,
	// Observations
	output logic [15:0]      mem_addr,
	output logic [15:0]      mem_wdata,
	output logic [15:0]      latch_q,
	output int               strobe_len,
	output int               n_wr,
	output int               n_rd
);
	logic [15:0] stale_r = 16'h0000; // Inverse of last level, idle lines
	logic [15:0] far_drv;      // Level the far side puts on the lines
	logic        far_on;       // Far side drives
	logic        was_wr_r;     // Last strobe run was a write
	int          run_r = 0;    // Strobe low clocks so far
	int          age_r = 8;    // Clocks since address strobe
	initial n_wr = 0;
	initial n_rd = 0;
	////////////////////////////////////////////////////////////////////
	// Memory answers read strobe, latch answers port read enable
	always_comb begin
		far_on  = !master_read_strobe_n || !port_read_enable_n || host_oe;
		far_drv = !master_read_strobe_n ? RDATA
			: !port_read_enable_n ? latch_fill : host_data;
	end
	// Undriven lines never keep the last level
	assign bus_in[7:0]  = bus_oe_lo ? bus_out[7:0]
		: far_on ? far_drv[7:0] : stale_r[7:0];
	assign bus_in[15:8] = bus_oe_hi ? bus_out[15:8]
		: far_on ? far_drv[15:8] : stale_r[15:8];
	assign addr_latch_strobe_in = addr_latch_strobe_oe
		? addr_latch_strobe_out : host_als;
	// Slow memory asks for waits from t1 on, so t3 sees it
	assign ready = slow && (addr_latch_strobe_out || age_r < 3);
	////////////////////////////////////////////////////////////////////
	// Address latch, write capture, external latch and run length
	// Plain always: the counters also start from an initial block
	always @(posedge clk) begin
		stale_r <= ~bus_in;
		age_r   <= addr_latch_strobe_out ? 0 : age_r + 1;
		if (addr_latch_strobe_out) mem_addr <= bus_in;
		if (!master_write_strobe_n) mem_wdata <= bus_in;
		if (!port_write_strobe_n) latch_q <= bus_in;
		if (!master_write_strobe_n || !master_read_strobe_n) begin
			run_r    <= run_r + 1;
			was_wr_r <= !master_write_strobe_n;
		end else if (run_r != 0) begin
			strobe_len <= run_r;
			run_r      <= 0;
			if (was_wr_r) n_wr <= n_wr + 1;
			else n_rd <= n_rd + 1;
		end
	end
endmodule : lbi_far_side

//--- test/test_nic_local_bus_interface.sv
// Testbench: register port, buffered and remote memory cycles.
// Assumes the design package, interface and modules compile first.
`timescale 1ns/1ps
module test_nic_local_bus_interface;
	import nic_lbi_pkg::*;
	localparam logic [15:0] MEM_WORD = 16'hc3a5; // Memory read word
	// Stimulus, all valued at time zero
	logic clk = 1'b0, srst = 1'b1, slave_sel_n = 1'b1;
	logic slave_write_strobe_n = 1'b1, slave_read_strobe_n = 1'b1;
	logic bus_grant = 1'b0, latch_read_done = 1'b0;
	logic latch_write_done = 1'b0, push_valid = 1'b0;
	logic host_als = 1'b1, host_oe = 1'b0, slow = 1'b0;
	logic [3:0]  register_select = 4'h0;
	logic [15:0] host_data = 16'h0000, latch_fill = 16'h0000;
	logic [31:0] push_data = 32'h0000_0000;
	// Design outputs and wires
	logic access_ack_n, bus_oe_lo, bus_oe_hi, addr_latch_strobe_in;
	logic addr_latch_strobe_out, addr_latch_strobe_oe, ready;
	logic master_write_strobe_n, master_read_strobe_n, master_strobe_oe;
	logic bus_request_out, port_read_enable_n, port_write_strobe_n;
	logic remote_port_request, push_ready;
	logic [15:0] bus_in, bus_out, mem_addr, mem_wdata, latch_q;
	int strobe_len, n_wr, n_rd;
	int n_mismatch = 0, check_count = 0;
	always #25 clk = ~clk;
	nic_local_bus_interface nic_local_bus_interface_inst (
		.clk(clk), .srst(srst), .slave_sel_n(slave_sel_n),
		.register_select(register_select),
		.slave_write_strobe_n(slave_write_strobe_n),
		.slave_read_strobe_n(slave_read_strobe_n),
		.access_ack_n(access_ack_n), .bus_in(bus_in), .bus_out(bus_out),
		.bus_oe_lo(bus_oe_lo), .bus_oe_hi(bus_oe_hi),
		.addr_latch_strobe_in(addr_latch_strobe_in),
		.addr_latch_strobe_out(addr_latch_strobe_out),
		.addr_latch_strobe_oe(addr_latch_strobe_oe),
		.master_write_strobe_n(master_write_strobe_n),
		.master_read_strobe_n(master_read_strobe_n),
		.master_strobe_oe(master_strobe_oe), .ready(ready),
		.bus_request_out(bus_request_out), .bus_grant(bus_grant),
		.port_read_enable_n(port_read_enable_n),
		.port_write_strobe_n(port_write_strobe_n),
		.remote_port_request(remote_port_request),
		.latch_read_done(latch_read_done),
		.latch_write_done(latch_write_done), .push_valid(push_valid),
		.push_ready(push_ready), .push_data(push_data));
	lbi_far_side #(.RDATA(MEM_WORD)) lbi_far_side_inst (
		.clk(clk), .bus_out(bus_out), .bus_oe_lo(bus_oe_lo),
		.bus_oe_hi(bus_oe_hi), .addr_latch_strobe_out(addr_latch_strobe_out),
		.addr_latch_strobe_oe(addr_latch_strobe_oe),
		.master_write_strobe_n(master_write_strobe_n),
		.master_read_strobe_n(master_read_strobe_n),
		.port_read_enable_n(port_read_enable_n),
		.port_write_strobe_n(port_write_strobe_n), .host_als(host_als),
		.host_oe(host_oe), .host_data(host_data), .slow(slow),
		.latch_fill(latch_fill), .bus_in(bus_in),
		.addr_latch_strobe_in(addr_latch_strobe_in), .ready(ready),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .latch_q(latch_q),
		.strobe_len(strobe_len), .n_wr(n_wr), .n_rd(n_rd));
	////////////////////////////////////////////////////////////////////
	// Shared helpers
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic complete_run;
		if (n_mismatch == 0 && check_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : complete_run
	// Bounded waits; running out counts as a mismatch
	task automatic wait_ack(input logic lvl);
		for (int i = 0; i < 20; i++) begin
			@(negedge clk);
			if (access_ack_n === lvl) return;
		end
		check(access_ack_n, lvl);
		complete_run;
	endtask : wait_ack
	task automatic wait_mem(input logic wr);
		int start;
		start = wr ? n_wr : n_rd;
		for (int i = 0; i < 60; i++) begin
			@(negedge clk);
			if ((wr ? n_wr : n_rd) != start) return;
		end
		check(32'h0, 32'h1);
		complete_run;
	endtask : wait_mem
	// One host register access; select is latched then scrambled
	task automatic reg_acc(input logic wr, input logic [3:0] code,
		input logic [7:0] wd, input logic [7:0] exp);
		@(posedge clk);
		slave_sel_n     <= 1'b0;
		register_select <= code;
		tick(3);
		host_als        <= 1'b0;
		tick(4);
		register_select <= ~code;
		host_data       <= {8'h00, wd};
		host_oe         <= wr;
		slave_write_strobe_n <= !wr;
		slave_read_strobe_n  <= wr;
		wait_ack(1'b0);
		if (!wr) check({bus_oe_lo, bus_out[7:0]}, {1'b1, exp});
		@(posedge clk);
		slave_write_strobe_n <= 1'b1;
		slave_read_strobe_n  <= 1'b1;
		tick(4);
		host_oe     <= 1'b0;
		slave_sel_n <= 1'b1;
		host_als    <= 1'b1;
		wait_ack(1'b1);
	endtask : reg_acc
	////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_deselected;
		@(posedge clk);
		slave_read_strobe_n <= 1'b0;
		tick(10);
		check({access_ack_n, bus_oe_lo}, 2'b10);
		slave_read_strobe_n <= 1'b1;
	endtask : t_deselected
	task automatic t_local(input logic word, input logic slw,
		input logic [31:0] d);
		logic [15:0] exp_w;
		exp_w = word ? d[15:0] : {d[31:24], d[7:0]};
		reg_acc(1'b1, REG_CTRL, {7'h00, word}, 8'h00);
		@(posedge clk);
		slow       <= slw;
		push_valid <= 1'b1;
		push_data  <= d;
		@(negedge clk);
		check(push_ready, 1'b1);
		@(posedge clk);
		push_valid <= 1'b0;
		tick(6);
		check({bus_request_out, master_strobe_oe}, 2'b10);
		bus_grant <= 1'b1;
		wait_mem(1'b1);
		check(mem_addr, d[31:16]);
		check(mem_wdata, exp_w);
		check(slw ? strobe_len > 2 : strobe_len == 2, 1'b1);
		@(posedge clk);
		bus_grant <= 1'b0;
		slow      <= 1'b0;
		tick(6);
		check(bus_request_out, 1'b0);
	endtask : t_local
	task automatic t_remote;
		reg_acc(1'b1, REG_CTRL, 8'h01, 8'h00);
		reg_acc(1'b1, REG_RADDR_LO, 8'h34, 8'h00);
		reg_acc(1'b1, REG_RADDR_HI, 8'h12, 8'h00);
		reg_acc(1'b1, REG_RCNT_LO, 8'h02, 8'h00);
		reg_acc(1'b1, REG_RCNT_HI, 8'h00, 8'h00);
		tick(3);
		check(remote_port_request, 1'b1);
		latch_fill       <= 16'h5aa5;
		bus_grant        <= 1'b1;
		latch_write_done <= 1'b1;
		tick(4);
		latch_write_done <= 1'b0;
		wait_mem(1'b1);
		check(mem_addr, 16'h1234);
		check(mem_wdata, 16'h5aa5);
		tick(4);
		check(remote_port_request, 1'b1);
		latch_read_done <= 1'b1;
		tick(4);
		latch_read_done <= 1'b0;
		wait_mem(1'b0);
		check(mem_addr, 16'h1236);
		check(latch_q, MEM_WORD);
		tick(4);
		check(remote_port_request, 1'b0);
		bus_grant <= 1'b0;
	endtask : t_remote
	////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		tick(8);
		srst <= 1'b0;
		tick(2);
		check({master_strobe_oe, addr_latch_strobe_oe}, 2'b00);
		tick(2);
		check({master_strobe_oe, bus_request_out, access_ack_n}, 3'b001);
		t_deselected;
		reg_acc(1'b1, REG_CTRL, 8'h01, 8'h00);
		reg_acc(1'b0, REG_CTRL, 8'h00, 8'h01);
		reg_acc(1'b0, 4'hf, 8'h00, 8'h00);
		t_local(1'b0, 1'b0, 32'h4321_0077);
		t_local(1'b1, 1'b0, 32'h1000_beef);
		t_local(1'b1, 1'b1, 32'h2002_5a5a);
		t_remote;
		complete_run;
	end
endmodule : test_nic_local_bus_interface
